/* hdl/pps_pkg.sv */
package pps_pkg;

   // ==========================================
   // Register map
   localparam logic [15:0] PUMP_MULT_ADDR = 16'h3003;
   localparam logic [15:0] DIV_SEL_ADDR = 16'h3004;
   localparam logic [7:0] PUMP_MULT_RESET = 8'h1c;
   localparam logic [7:0] DIV_SEL_RESET = 8'h02;

   // ==========================================
   // Field positions
   localparam int PUMP_LSB = 5;
   localparam int PUMP_W = 3;
   localparam int MULT_LSB = 0;
   localparam int MULT_W = 5;
   localparam int DEBUG_LSB = 4;
   localparam int DEBUG_W = 4;
   localparam int SDIV_LSB = 2;
   localparam int PDIV_LSB = 0;
   localparam int DIV_W = 2;

   // ==========================================
   // Clock multiplier arithmetic
   localparam logic [5:0] FEEDBACK_BASE = 6'h20;
   // Pre-divider in half steps: /1 /1.5 /2 /3
   localparam logic [2:0] PDIV_HALVES_0 = 3'h2;
   localparam logic [2:0] PDIV_HALVES_1 = 3'h3;
   localparam logic [2:0] PDIV_HALVES_2 = 3'h4;
   localparam logic [2:0] PDIV_HALVES_3 = 3'h6;

   // ==========================================
   // Pad operating condition
   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_STANDBY = 2'b01,
      PM_POWER_DOWN_PIN = 2'b11
   } pps_mode_t;

   // ie: input buffer on, oe: driver on, o: driven level
   typedef struct packed {
      logic ie;
      logic oe;
      logic o;
   } pps_pad_t;

   localparam int DVP_PADS = 12;
   localparam int FIXED_INPUTS = 7;

   typedef struct packed {
      logic [5:0] feedback;
      logic [2:0] pump;
      logic [2:0] sdiv;
      logic [2:0] pdiv_halves;
      logic [6:0] ratio_num;
      logic [4:0] ratio_den;
   } pps_pll_cfg_t;

endpackage

/* hdl/pps_top.sv */
// What this block does
// - Feedback factor is thirty-two minus low five bits
// - Top three bits select pump current
// - System divider codes divide by one to four
// - Pre-divider codes divide by 1, 1.5, 2, 3
// - Power-down pin active high, pulled low
// - Flash clock and data-out pads follow overlay enable
// - Flash select drives high in overlay standby
// - Control bus pads input, open-drain; float powered down
// - Pixel pads input normally, high-z powered down, configurable
// - Crystal out high, crystal in floats powered down
// - Video pads open-drain, high-z powered down
// - Strap and mode pads always inputs
// - Power-down gates every internal block clock
// - Registers keep contents through power-down
// - Standby suspends activity, clock keeps running
module pps_top (
   input wire logic clk, // Reference clock
   input wire logic rst_n, // Power-on reset
   input wire logic power_down_pin, // Hardware power-down, high active
   input wire logic sw_standby, // Software standby request
   input wire logic overlay_enable, // Overlay enable strap
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [15:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic spi_clock_int, // Overlay master clock
   input wire logic spi_out_int, // Overlay master data out
   input wire logic spi_select_int, // Overlay master select
   input wire logic ctrl_bus_drive_low, // Control bus data pull request
   input wire logic crystal_in, // Oscillator input level
   input wire logic [1:0] video_pull, // Video pads pull requests
   input wire logic dvp_pd_drive, // Drive pixel pads low in power-down
   output logic [7:0] reg_rdata, // Register read data
   output pps_pkg::pps_pll_cfg_t pll_cfg, // Clock multiplier settings
   output logic core_clock_enable, // Clock gate for internal blocks
   output logic core_active, // Internal activity allowed
   output pps_pkg::pps_pad_t flash_spi_clock, // Flash clock pad
   output pps_pkg::pps_pad_t flash_spi_out, // Flash data-out pad
   output pps_pkg::pps_pad_t flash_spi_select, // Flash select pad
   output pps_pkg::pps_pad_t flash_spi_in, // Flash data-in pad
   output pps_pkg::pps_pad_t ctrl_bus_clock, // Control bus clock pad
   output pps_pkg::pps_pad_t ctrl_bus_data, // Control bus data pad
   output pps_pkg::pps_pad_t crystal_out, // Crystal output pad
   output pps_pkg::pps_pad_t crystal_in_pad, // Crystal input pad
   output pps_pkg::pps_pad_t [1:0] video_dac, // Video pads, pos then neg
   output pps_pkg::pps_pad_t [pps_pkg::DVP_PADS-1:0] dvp_pads, // Pixel pads
   output logic [pps_pkg::FIXED_INPUTS-1:0] fixed_inputs_ie // Strap pads
);

   // ==========================================
   // Helpers
   function automatic pps_pkg::pps_pad_t pad(input logic ie, input logic oe, input logic o);
      pps_pkg::pps_pad_t p;
      p.ie = ie;
      p.oe = oe;
      p.o = o;
      return p;
   endfunction

   function automatic logic [2:0] pdiv_halves(input logic [1:0] code);
      case (code)
         2'b00: pdiv_halves = pps_pkg::PDIV_HALVES_0;
         2'b01: pdiv_halves = pps_pkg::PDIV_HALVES_1;
         2'b10: pdiv_halves = pps_pkg::PDIV_HALVES_2;
         default: pdiv_halves = pps_pkg::PDIV_HALVES_3;
      endcase
   endfunction

   // ==========================================
   // Operating condition
   // Pad pull-down lives in the pad ring; here a high level alone means power-down
   pps_pkg::pps_mode_t mode;
   always_comb begin
      if (power_down_pin) begin
         mode = pps_pkg::PM_POWER_DOWN_PIN;
      end else if (sw_standby) begin
         mode = pps_pkg::PM_STANDBY;
      end else begin
         mode = pps_pkg::PM_RUN;
      end
   end

   logic pd;
   logic sb;
   assign pd = (mode == pps_pkg::PM_POWER_DOWN_PIN);
   assign sb = (mode == pps_pkg::PM_STANDBY);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_clock_enable <= 1'b1;
         core_active <= 1'b1;
      end else begin
         core_clock_enable <= !pd;
         core_active <= (mode == pps_pkg::PM_RUN);
      end
   end

   // ==========================================
   // Registers
   logic [7:0] pump_mult_reg;
   logic [7:0] div_sel_reg;

   // Only power-on reset loads their defaults; power-down merely blocks writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pump_mult_reg <= pps_pkg::PUMP_MULT_RESET;
         div_sel_reg <= pps_pkg::DIV_SEL_RESET;
      end else if (reg_wr && !pd) begin
         if (reg_addr == pps_pkg::PUMP_MULT_ADDR) begin
            pump_mult_reg <= reg_wdata;
         end
         // Debug bits stored as written; software keeps them zero
         if (reg_addr == pps_pkg::DIV_SEL_ADDR) begin
            div_sel_reg <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            pps_pkg::PUMP_MULT_ADDR: reg_rdata <= pump_mult_reg;
            pps_pkg::DIV_SEL_ADDR: reg_rdata <= div_sel_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // Clock multiplier settings
   // Range checks on the oscillator and reference are the host's duty
   pps_pkg::pps_pll_cfg_t cfg_next;
   // Widened first: a product kept at three bits wraps, 6 x 4 would read as 0
   logic [4:0] halves_wide;
   logic [4:0] sdiv_wide;
   always_comb begin
      cfg_next.feedback = pps_pkg::FEEDBACK_BASE
         - {1'b0, pump_mult_reg[pps_pkg::MULT_LSB +: pps_pkg::MULT_W]};
      cfg_next.pump = pump_mult_reg[pps_pkg::PUMP_LSB +: pps_pkg::PUMP_W];
      cfg_next.sdiv = {1'b0, div_sel_reg[pps_pkg::SDIV_LSB +: pps_pkg::DIV_W]} + 3'h1;
      cfg_next.pdiv_halves = pdiv_halves(div_sel_reg[pps_pkg::PDIV_LSB +: pps_pkg::DIV_W]);
      // f_sys = f_ref * ratio_num / ratio_den, halves folded into both terms
      cfg_next.ratio_num = {cfg_next.feedback, 1'b0};
      halves_wide = {2'b00, cfg_next.pdiv_halves};
      sdiv_wide = {2'b00, cfg_next.sdiv};
      cfg_next.ratio_den = halves_wide * sdiv_wide;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_cfg <= '0;
      end else begin
         pll_cfg <= cfg_next;
      end
   end

   // ==========================================
   // Flash pads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_spi_clock <= pad(1'b1, 1'b0, 1'b0);
         flash_spi_out <= pad(1'b1, 1'b0, 1'b0);
         flash_spi_select <= pad(1'b1, 1'b0, 1'b0);
         flash_spi_in <= pad(1'b1, 1'b0, 1'b0);
      end else if (!overlay_enable) begin
         flash_spi_clock <= pad(!pd, 1'b0, 1'b0);
         flash_spi_out <= pad(!pd, 1'b0, 1'b0);
         flash_spi_select <= pad(!pd, 1'b0, 1'b0);
         flash_spi_in <= pad(!pd, 1'b0, 1'b0);
      end else begin
         flash_spi_clock <= pad(1'b0, 1'b1, (!pd && !sb) ? spi_clock_int : 1'b0);
         flash_spi_out <= pad(1'b0, 1'b1, (!pd && !sb) ? spi_out_int : 1'b0);
         flash_spi_select <= pad(1'b0, 1'b1, pd ? 1'b0 : (sb ? 1'b1 : spi_select_int));
         flash_spi_in <= pad(!pd, 1'b0, 1'b0);
      end
   end

   // ==========================================
   // Control bus, crystal, video and strap pads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_bus_clock <= pad(1'b1, 1'b0, 1'b0);
         ctrl_bus_data <= pad(1'b1, 1'b0, 1'b0);
         crystal_out <= pad(1'b0, 1'b1, 1'b0);
         crystal_in_pad <= pad(1'b1, 1'b0, 1'b0);
         video_dac <= '0;
         fixed_inputs_ie <= '1;
      end else begin
         ctrl_bus_clock <= pad(!pd, 1'b0, 1'b0);
         ctrl_bus_data <= pad(!pd, !pd && ctrl_bus_drive_low, 1'b0);
         crystal_out <= pad(1'b0, 1'b1, pd ? 1'b1 : !crystal_in);
         crystal_in_pad <= pad(!pd, 1'b0, 1'b0);
         for (int i = 0; i < 2; i++) begin
            video_dac[i] <= pad(1'b0, !pd && video_pull[i], 1'b0);
         end
         fixed_inputs_ie <= '1;
      end
   end

   // ==========================================
   // Pixel port pads
   genvar g;
   generate
      for (g = 0; g < pps_pkg::DVP_PADS; g++) begin : g_dvp
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               dvp_pads[g] <= pad(1'b1, 1'b0, 1'b0);
            end else begin
               dvp_pads[g] <= pad(!pd, pd && dvp_pd_drive, 1'b0);
            end
         end
      end
   endgenerate

endmodule

/* tb/pps_properties.sv */
// ==========================================
// Port checker for the clock and pad control block
module pps_properties (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic power_down_pin, // Power-down
   input wire logic sw_standby, // Standby
   input wire logic reg_wr, // Write
   input wire logic [15:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Data
   input wire logic dvp_pd_drive, // Pixel drive
   input wire pps_pkg::pps_pll_cfg_t pll_cfg, // Settings
   input wire logic core_clock_enable, // Gate
   input wire logic core_active, // Activity
   input wire pps_pkg::pps_pad_t ctrl_bus_data, // Bus data
   input wire pps_pkg::pps_pad_t crystal_out, // Crystal out
   input wire pps_pkg::pps_pad_t [pps_pkg::DVP_PADS-1:0] dvp_pads, // Pixel pads
   input wire logic [pps_pkg::FIXED_INPUTS-1:0] fixed_inputs_ie // Straps
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic wr_a;
   logic wr_b;
   // Writes in power-down are dropped, so they start nothing
   assign wr_a = reg_wr && !power_down_pin && reg_addr == pps_pkg::PUMP_MULT_ADDR;
   assign wr_b = reg_wr && !power_down_pin && reg_addr == pps_pkg::DIV_SEL_ADDR;
   chk_feedback_calc: assert property (wr_a |=> ##1
      pll_cfg.feedback == 6'h20 - $past(reg_wdata[4:0], 2) && pll_cfg.pump == $past(reg_wdata[7:5], 2))
      else $error("multiplier fields wrong");
   chk_sysdiv_map: assert property (wr_b |=> ##1
      pll_cfg.sdiv == $past(reg_wdata[3:2], 2) + 3'h1) else $error("system divider wrong");
   chk_ratio_link: assert property (pll_cfg.ratio_num == {pll_cfg.feedback, 1'b0}
      && pll_cfg.ratio_den == pll_cfg.pdiv_halves * pll_cfg.sdiv) else $error("ratio wrong");
   chk_gate_pd: assert property (1'b1 |=>
      core_clock_enable == !$past(power_down_pin)) else $error("clock gate wrong");
   chk_standby_act: assert property (1'b1 |=>
      core_active == !($past(power_down_pin) || $past(sw_standby))) else $error("activity wrong");
   chk_pd_float: assert property (power_down_pin |=>
      ctrl_bus_data == 3'h0 && crystal_out == 3'h3) else $error("power-down pads wrong");
   chk_pixel_pd: assert property (power_down_pin && !dvp_pd_drive |=> dvp_pads == '0)
      else $error("pixel pads not floating");
   chk_strap_ie: assert property (&fixed_inputs_ie)
      else $error("strap pad not input");
endmodule
bind pps_top pps_properties i_pps_properties (.*);

/* tb/pps_host_model.sv */
// ==========================================
// Host side of the byte register port
module pps_host_model (
   input wire logic clk, // Clock
   input wire logic [7:0] reg_rdata, // Read data
   output logic reg_wr, // Write strobe
   output logic reg_rd, // Read strobe
   output logic [15:0] reg_addr, // Address
   output logic [7:0] reg_wdata // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Sampled a cycle late; the data holds until the next read
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
endmodule

/* tb/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, power_down_pin, sw_standby, overlay_enable, reg_wr, reg_rd, lv, f, g;
   logic spi_clock_int, spi_out_int, spi_select_int, ctrl_bus_drive_low, crystal_in;
   logic dvp_pd_drive, core_clock_enable, core_active;
   logic [1:0] video_pull;
   logic [4:0] m;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   // Every pre- and system-divider code once; the loop stays near 98 MHz
   logic [15:0] tv [4] = '{16'h3c00, 16'hfa05, 16'h580a, 16'hb40f};
   // Modelled reference of 24.545452 MHz; the bench clock only paces the logic
   localparam longint REF_HZ = 64'h17688ac;
   longint vco;
   logic [pps_pkg::FIXED_INPUTS-1:0] fixed_inputs_ie;
   pps_pkg::pps_pll_cfg_t pll_cfg;
   pps_pkg::pps_pad_t flash_spi_clock, flash_spi_out, flash_spi_select, flash_spi_in;
   pps_pkg::pps_pad_t ctrl_bus_clock, ctrl_bus_data, crystal_out, crystal_in_pad;
   pps_pkg::pps_pad_t [1:0] video_dac;
   pps_pkg::pps_pad_t [pps_pkg::DVP_PADS-1:0] dvp_pads;
   int bad_count, num_checks, cyc;
   assign {spi_clock_int, spi_out_int, crystal_in, ctrl_bus_drive_low} = {4{lv}};
   assign spi_select_int = !lv;
   assign video_pull = {lv, !lv};
   pps_top i_pps_top (.*);
   pps_host_model i_pps_host_model (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
      num_checks++;
      if (gv !== ev) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, gv, ev);
      end
   endtask
   function automatic pps_pkg::pps_pll_cfg_t cfg(input logic [7:0] a, input logic [7:0] b);
      logic [5:0] fb;
      logic [2:0] h, v;
      logic [4:0] r;
      fb = 6'h20 - {1'b0, a[4:0]};
      v = {1'b0, b[3:2]} + 3'h1;
      h = b[1] ? (b[0] ? 3'h6 : 3'h4) : (b[0] ? 3'h3 : 3'h2);
      r = h * v;
      cfg = {fb, a[7:5], v, h, fb, 1'b0, r};
   endfunction
   task automatic drive(input logic [4:0] v);
      @(posedge clk);
      {power_down_pin, sw_standby, overlay_enable, dvp_pd_drive, lv} <= v;
      @(posedge clk);
      #1;
   endtask
   task automatic prog(input logic [7:0] a, input logic [7:0] b);
      i_pps_host_model.wr(pps_pkg::PUMP_MULT_ADDR, a);
      i_pps_host_model.wr(pps_pkg::DIV_SEL_ADDR, b);
      repeat (2) @(posedge clk);
      #1;
      chk(32'(pll_cfg), 32'(cfg(a, b)));
      vco = REF_HZ * 64'h2 * pll_cfg.feedback / pll_cfg.pdiv_halves;
      chk(32'(vco >= 64'h5b8d800 && vco <= 64'h7270e00), 32'h1);
      i_pps_host_model.rd(pps_pkg::PUMP_MULT_ADDR, rv);
      chk(32'(rv), 32'(a));
      i_pps_host_model.rd(pps_pkg::DIV_SEL_ADDR, rv);
      chk(32'(rv), 32'(b));
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      {power_down_pin, sw_standby, overlay_enable, dvp_pd_drive, lv} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(32'(pll_cfg), 32'(cfg(8'h1c, 8'h02)));
      i_pps_host_model.rd(pps_pkg::PUMP_MULT_ADDR, rv);
      chk(32'(rv), 32'h1c);
      i_pps_host_model.rd(pps_pkg::DIV_SEL_ADDR, rv);
      chk(32'(rv), 32'h02);
      // Debug bits kept at zero; every divider code used once
      foreach (tv[k]) prog(tv[k][15:8], tv[k][7:0]);
      i_pps_host_model.wr(16'h3005, 8'h55);
      i_pps_host_model.rd(16'h3005, rv);
      chk(32'(rv), 32'h0);
      drive(5'h10);
      i_pps_host_model.wr(pps_pkg::PUMP_MULT_ADDR, 8'h07);
      i_pps_host_model.rd(pps_pkg::PUMP_MULT_ADDR, rv);
      chk(32'(rv), 32'hb4);
      drive(5'h00);
      chk(32'(pll_cfg), 32'(cfg(8'hb4, 8'h0f)));
      for (int i = 0; i < 32; i++) begin
         m = 5'(i);
         drive(m);
         f = !m[4] && !m[3] && m[0];
         g = !m[4] && (m[3] || !m[0]);
         chk(32'(core_clock_enable), 32'(!m[4]));
         chk(32'(core_active), 32'(!(m[4] || m[3])));
         chk(32'({flash_spi_clock, flash_spi_out}),
            32'({2{m[2] ? {2'b01, f} : {!m[4], 2'b00}}}));
         chk(32'(flash_spi_in), 32'({!m[4], 2'b00}));
         chk(32'(flash_spi_select), 32'(m[2] ? {2'b01, g} : {!m[4], 2'b00}));
         chk(32'({ctrl_bus_clock, ctrl_bus_data}), m[4] ? 32'h0 : 32'({4'h9, m[0], 1'b0}));
         chk(32'({crystal_in_pad, crystal_out}), m[4] ? 32'h3 : 32'({5'h11, !m[0]}));
         chk(32'(video_dac), m[4] ? 32'h0 : 32'({1'b0, m[0], 2'b00, !m[0], 1'b0}));
         chk(32'(fixed_inputs_ie), 32'h7f);
         for (int j = 0; j < pps_pkg::DVP_PADS; j++)
            chk(32'(dvp_pads[j]), m[4] ? 32'({1'b0, m[1], 1'b0}) : 32'h4);
      end
      results();
   end
endmodule
